/* rtl/ucf_pkg.sv */
// Package: register map, field positions and reset values for the serial port core
package ucf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] OFF_CTRL_C   = 8'h08;
  localparam logic [7:0] OFF_DIV_LOW  = 8'h0C;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h10;
  localparam logic [7:0] OFF_DATA     = 8'h14;
  localparam logic [7:0] OFF_PIN_DIR  = 8'h18;
  // ctrl_status_a fields
  localparam int A_PAR_ERR  = 2;
  localparam int A_DBL      = 1;
  localparam int A_FRM_ERR  = 4;
  localparam int A_BUF_EMPTY = 5;
  localparam int A_TXC      = 6;
  localparam int A_RXC      = 7;
  // ctrl_status_b fields
  localparam int B_RX_EN    = 4;
  localparam int B_TX_EN    = 3;
  localparam int B_CSZ2     = 2;
  localparam int B_RX_NINTH = 1;
  localparam int B_TX_NINTH = 0;
  // ctrl_status_c fields
  localparam int C_SYNC     = 6;
  localparam int C_PAR_HI   = 5;
  localparam int C_PAR_LO   = 4;
  localparam int C_STOP2    = 3;
  localparam int C_CSZ1     = 2;
  localparam int C_CSZ0     = 1;
  localparam int C_POL      = 0;
  // pin direction register field
  localparam int D_XCK_OUT  = 0;
  // Reset values
  localparam logic [7:0]  RST_CTRL_A = 8'h00;
  localparam logic [7:0]  RST_CTRL_B = 8'h00;
  localparam logic [7:0]  RST_CTRL_C = 8'h06;
  localparam logic [11:0] RST_DIV    = 12'h000;
  // Bit-clock moduli minus one: normal, double speed, synchronous
  localparam logic [3:0] OS_NORM_M1 = 4'hF;
  localparam logic [3:0] OS_DBL_M1  = 4'h7;
  localparam logic [3:0] OS_SYNC_M1 = 4'h1;
  localparam logic [2:0] CSZ_NINE   = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } ucf_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } ucf_rx_e;
endpackage : ucf_pkg

/* rtl/ucf_top.sv */
// Serial port core: baud generator, clock modes, frame engine and AXI4-Lite registers
// What this block does
// - Four clock modes, sync bit picks async/sync
// - In sync, pin direction picks master/slave
// - Transfer clock pin used only in sync
// - Divisor counter reloads at zero, low write
// - Tick at zero: system clock over divisor+1
// - Transmitter divides ticks by 16/8/2
// - Receiver uses ticks with 2/8/16 states
// - Divisor is 12 bits from high/low
// - Double speed cuts divisor 16 to 8
// - Double speed ignored in synchronous mode
// - Double speed receiver takes 8 samples
// - Slave clock synchronised then edge detected
// - Sample on edge opposite output change
// - Polarity picks change and sample edges
// - All thirty frame formats accepted
// - Start low, data LSB first, parity, stop high
// - Frames back to back or idle high
// - One shared frame format for both directions
// - Second stop ignored, error on first low
// - Parity is xor of data, odd inverts
// - Size 7 means nine bits, ninth from control
// - Parity inserted when upper mode bit set
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ucf_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,      // System clock
  input  wire logic              aresetn,   // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] awaddr,    // Write address
  input  wire logic              awvalid,   // Write address valid
  output logic                   awready,   // Write address ready
  input  wire logic [31:0]       wdata,     // Write data
  input  wire logic [3:0]        wstrb,     // Write byte enables
  input  wire logic              wvalid,    // Write data valid
  output logic                   wready,    // Write data ready
  output logic [1:0]             bresp,     // Write response
  output logic                   bvalid,    // Write response valid
  input  wire logic              bready,    // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,    // Read address
  input  wire logic              arvalid,   // Read address valid
  output logic                   arready,   // Read address ready
  output logic [31:0]            rdata,     // Read data
  output logic [1:0]             rresp,     // Read response
  output logic                   rvalid,    // Read data valid
  input  wire logic              rready,    // Read data ready
  input  wire logic              rxd_in,    // Serial input pin
  output logic                   txd_out,   // Serial output pin
  input  wire logic              xck_in,    // Transfer clock pin input
  output logic                   xck_out,   // Transfer clock pin output
  output logic                   xck_oe     // Transfer clock pin drive enable
);
  typedef struct packed {
    logic              awrdy, wrdy, bval, arrdy, rval;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              aw_have, w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic [7:0]        ctrl_a, ctrl_b, ctrl_c;
    logic [11:0]       div;
    logic              xck_dir;
    logic [11:0]       baud_cnt;
    logic [3:0]        tx_pre;
    logic              phase;
    logic              xs1, xs2, xs3;
    logic              rs1, rs2;
    ucf_pkg::ucf_tx_e  tx_st;
    logic [8:0]        tx_buf;
    logic              buf_full;
    logic [8:0]        tx_sh;
    logic [3:0]        tx_bits;
    logic              txd, txc;
    logic              xck_o, xck_en;
    ucf_pkg::ucf_rx_e  rx_st;
    logic [3:0]        rx_cnt;
    logic [3:0]        rx_bits;
    logic [8:0]        rx_sh;
    logic              rx_par;
    logic [8:0]        rx_data;
    logic              rxc, fe, pe;
  } ucf_state_s;

  ucf_state_s s_q, s_d;

  assign awready = s_q.awrdy;
  assign wready  = s_q.wrdy;
  assign bvalid  = s_q.bval;
  assign bresp   = s_q.bresp;
  assign arready = s_q.arrdy;
  assign rvalid  = s_q.rval;
  assign rresp   = s_q.rresp;
  assign rdata   = s_q.rdata;
  assign txd_out = s_q.txd;
  assign xck_out = s_q.xck_o;
  assign xck_oe  = s_q.xck_en;

  always_comb begin
    logic       sync, master, slave, dbl, pol, tick, stop2, par_en, par_odd;
    logic       x_rise, x_fall, chg_edge, smp_edge, tx_bit, rx_smp, rbit, frame_end;
    logic [3:0] os_m1, n_m1;
    logic [2:0] csz;
    logic       wr_go, rd_go, wr_ok, rd_ok;
    logic [7:0] waddr, raddr, rv;
    logic       wr_a, wr_b, wr_c, wr_lo, wr_hi, wr_dat, wr_dir, rd_dat;
    s_d      = s_q;
    sync     = s_q.ctrl_c[ucf_pkg::C_SYNC];
    master   = sync && s_q.xck_dir;
    slave    = sync && !s_q.xck_dir;
    dbl      = s_q.ctrl_a[ucf_pkg::A_DBL] && !sync;
    pol      = s_q.ctrl_c[ucf_pkg::C_POL];
    stop2    = s_q.ctrl_c[ucf_pkg::C_STOP2];
    par_en   = s_q.ctrl_c[ucf_pkg::C_PAR_HI];
    par_odd  = s_q.ctrl_c[ucf_pkg::C_PAR_LO];
    csz      = {s_q.ctrl_b[ucf_pkg::B_CSZ2], s_q.ctrl_c[ucf_pkg::C_CSZ1],
                s_q.ctrl_c[ucf_pkg::C_CSZ0]};
    // Reserved sizes 4..6 fall back to eight bits
    if (csz == ucf_pkg::CSZ_NINE) begin
      n_m1 = 4'h8;
    end else if (csz[2]) begin
      n_m1 = 4'h7;
    end else begin
      n_m1 = {2'b00, csz[1:0]} + 4'h4;
    end
    if (sync) begin
      os_m1 = ucf_pkg::OS_SYNC_M1;
    end else if (dbl) begin
      os_m1 = ucf_pkg::OS_DBL_M1;
    end else begin
      os_m1 = ucf_pkg::OS_NORM_M1;
    end
    tick = (s_q.baud_cnt == 12'h000);

    // Pin input synchronisers; data uses the second stage, clock edges compare the second and third
    s_d.xs1 = xck_in;
    s_d.xs2 = s_q.xs1;
    s_d.xs3 = s_q.xs2;
    s_d.rs1 = rxd_in;
    s_d.rs2 = s_q.rs1;
    rbit    = s_q.rs2;
    x_rise  = s_q.xs2 && !s_q.xs3;
    x_fall  = !s_q.xs2 && s_q.xs3;

    // Master clock: phase 0->1 is the change edge, 1->0 the sample edge
    if (master) begin
      if (tick) begin
        s_d.phase = !s_q.phase;
      end
    end else begin
      s_d.phase = 1'b0;
    end
    s_d.xck_o  = s_d.phase ^ pol;
    s_d.xck_en = master;
    if (master) begin
      chg_edge = tick && !s_q.phase;
      smp_edge = tick && s_q.phase;
    end else if (slave) begin
      chg_edge = pol ? x_fall : x_rise;
      smp_edge = pol ? x_rise : x_fall;
    end else begin
      chg_edge = 1'b0;
      smp_edge = 1'b0;
    end

    // Transmit bit clock
    tx_bit = 1'b0;
    if (sync) begin
      tx_bit = chg_edge;
    end else if (tick) begin
      if (s_q.tx_pre >= os_m1) begin
        s_d.tx_pre = 4'h0;
        tx_bit     = 1'b1;
      end else begin
        s_d.tx_pre = s_q.tx_pre + 4'h1;
      end
    end

    // AXI4-Lite write channel
    if (awvalid && s_q.awrdy) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wrdy) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    if (bready && s_q.bval) begin
      s_d.bval = 1'b0;
    end
    wr_go = s_q.aw_have && s_q.w_have && !s_q.bval;
    waddr = 8'(s_q.aw_addr);
    wr_ok = (waddr == ucf_pkg::OFF_CTRL_A) || (waddr == ucf_pkg::OFF_CTRL_B) ||
            (waddr == ucf_pkg::OFF_CTRL_C) || (waddr == ucf_pkg::OFF_DIV_LOW) ||
            (waddr == ucf_pkg::OFF_DIV_HIGH) || (waddr == ucf_pkg::OFF_DATA) ||
            (waddr == ucf_pkg::OFF_PIN_DIR);
    wr_a   = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_CTRL_A);
    wr_b   = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_CTRL_B);
    wr_c   = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_CTRL_C);
    wr_lo  = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_DIV_LOW);
    wr_hi  = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_DIV_HIGH);
    wr_dat = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_DATA);
    wr_dir = wr_go && s_q.w_lane0 && (waddr == ucf_pkg::OFF_PIN_DIR);
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bval    = 1'b1;
      s_d.bresp   = wr_ok ? ucf_pkg::RESP_OKAY : ucf_pkg::RESP_SLVERR;
    end
    if (wr_a) begin
      s_d.ctrl_a[ucf_pkg::A_DBL] = s_q.w_data[ucf_pkg::A_DBL];
      if (s_q.w_data[ucf_pkg::A_TXC]) begin
        s_d.txc = 1'b0;
      end
    end
    if (wr_b) begin
      s_d.ctrl_b[ucf_pkg::B_RX_EN]    = s_q.w_data[ucf_pkg::B_RX_EN];
      s_d.ctrl_b[ucf_pkg::B_TX_EN]    = s_q.w_data[ucf_pkg::B_TX_EN];
      s_d.ctrl_b[ucf_pkg::B_CSZ2]     = s_q.w_data[ucf_pkg::B_CSZ2];
      s_d.ctrl_b[ucf_pkg::B_TX_NINTH] = s_q.w_data[ucf_pkg::B_TX_NINTH];
    end
    if (wr_c) begin
      s_d.ctrl_c = {1'b0, s_q.w_data[6:0]};
    end
    if (wr_hi) begin
      s_d.div[11:8] = s_q.w_data[3:0];
    end
    if (wr_lo) begin
      s_d.div[7:0] = s_q.w_data;
    end
    if (wr_dir) begin
      s_d.xck_dir = s_q.w_data[ucf_pkg::D_XCK_OUT];
    end
    if (wr_dat) begin
      // Ninth bit comes from the control register, not from the write
      s_d.tx_buf   = {s_q.ctrl_b[ucf_pkg::B_TX_NINTH], s_q.w_data};
      s_d.buf_full = 1'b1;
    end
    s_d.awrdy = !s_d.aw_have && !s_d.bval;
    s_d.wrdy  = !s_d.w_have && !s_d.bval;

    // Baud generator
    if (wr_lo) begin
      s_d.baud_cnt = {s_q.div[11:8], s_q.w_data};
    end else if (tick) begin
      s_d.baud_cnt = s_q.div;
    end else begin
      s_d.baud_cnt = s_q.baud_cnt - 12'h001;
    end

    // Transmitter
    frame_end = 1'b0;
    if (tx_bit) begin
      unique case (s_q.tx_st)
        ucf_pkg::TX_IDLE: begin
          s_d.txd = 1'b1;
          frame_end = 1'b1;
        end
        ucf_pkg::TX_START: begin
          s_d.txd     = s_q.tx_sh[0];
          s_d.tx_bits = 4'h0;
          s_d.tx_st   = ucf_pkg::TX_DATA;
        end
        ucf_pkg::TX_DATA: begin
          if (s_q.tx_bits == n_m1) begin
            if (par_en) begin
              s_d.txd   = (^(s_q.tx_sh & ~(9'h1FF << (n_m1 + 4'h1)))) ^ par_odd;
              s_d.tx_st = ucf_pkg::TX_PAR;
            end else begin
              s_d.txd   = 1'b1;
              s_d.tx_st = ucf_pkg::TX_STOP1;
            end
          end else begin
            s_d.tx_bits = s_q.tx_bits + 4'h1;
            s_d.txd     = s_q.tx_sh[s_q.tx_bits + 4'h1];
          end
        end
        ucf_pkg::TX_PAR: begin
          s_d.txd   = 1'b1;
          s_d.tx_st = ucf_pkg::TX_STOP1;
        end
        ucf_pkg::TX_STOP1: begin
          if (stop2) begin
            s_d.tx_st = ucf_pkg::TX_STOP2;
          end else begin
            frame_end = 1'b1;
          end
        end
        ucf_pkg::TX_STOP2: begin
          frame_end = 1'b1;
        end
      endcase
    end
    if (frame_end) begin
      if (s_d.buf_full && s_q.ctrl_b[ucf_pkg::B_TX_EN]) begin
        // Next frame follows the last stop bit without a gap
        s_d.tx_sh    = s_d.tx_buf;
        s_d.buf_full = 1'b0;
        s_d.txd      = 1'b0;
        s_d.tx_st    = ucf_pkg::TX_START;
      end else begin
        if (s_q.tx_st != ucf_pkg::TX_IDLE) begin
          s_d.txc = 1'b1;
        end
        s_d.txd   = 1'b1;
        s_d.tx_st = ucf_pkg::TX_IDLE;
      end
    end

    // Receiver sample strobe
    rx_smp = 1'b0;
    if (sync) begin
      rx_smp = smp_edge;
    end else if (tick && s_q.rx_st != ucf_pkg::RX_IDLE) begin
      if (s_q.rx_cnt >= os_m1) begin
        s_d.rx_cnt = 4'h0;
        rx_smp     = 1'b1;
      end else begin
        s_d.rx_cnt = s_q.rx_cnt + 4'h1;
      end
    end

    // Data buffer read clears the complete flag; a new frame below wins
    rd_go = arvalid && s_q.arrdy;
    raddr = 8'(araddr);
    rd_dat = rd_go && (raddr == ucf_pkg::OFF_DATA);
    if (rd_dat) begin
      s_d.rxc = 1'b0;
    end

    unique case (s_q.rx_st)
      ucf_pkg::RX_IDLE: begin
        s_d.rx_cnt  = 4'h0;
        s_d.rx_bits = 4'h0;
        s_d.rx_par  = 1'b0;
        if (s_q.ctrl_b[ucf_pkg::B_RX_EN] && !rbit) begin
          if (sync) begin
            if (smp_edge) begin
              s_d.rx_st = ucf_pkg::RX_DATA;
            end
          end else if (tick) begin
            s_d.rx_st = ucf_pkg::RX_START;
          end
        end
      end
      ucf_pkg::RX_START: begin
        // Start bit rechecked at mid bit to reject glitches
        if (tick && s_q.rx_cnt == (os_m1 >> 1)) begin
          s_d.rx_cnt = 4'h0;
          s_d.rx_st  = rbit ? ucf_pkg::RX_IDLE : ucf_pkg::RX_DATA;
        end
      end
      ucf_pkg::RX_DATA: begin
        if (rx_smp) begin
          s_d.rx_sh[s_q.rx_bits] = rbit;
          s_d.rx_par = s_q.rx_par ^ rbit;
          s_d.rx_bits = s_q.rx_bits + 4'h1;
          if (s_q.rx_bits == n_m1) begin
            s_d.rx_st = par_en ? ucf_pkg::RX_PAR : ucf_pkg::RX_STOP;
          end
        end
      end
      ucf_pkg::RX_PAR: begin
        if (rx_smp) begin
          s_d.rx_par = s_q.rx_par ^ rbit ^ par_odd;
          s_d.rx_st  = ucf_pkg::RX_STOP;
        end
      end
      ucf_pkg::RX_STOP: begin
        if (rx_smp) begin
          // Only the first stop bit is checked
          s_d.rx_data = s_q.rx_sh & ~(9'h1FF << (n_m1 + 4'h1));
          s_d.fe      = !rbit;
          s_d.pe      = par_en && s_q.rx_par;
          s_d.rxc     = 1'b1;
          s_d.rx_sh   = 9'h000;
          s_d.rx_st   = ucf_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.rx_st = ucf_pkg::RX_IDLE;
      end
    endcase

    // AXI4-Lite read channel
    rd_ok = 1'b1;
    rv    = 8'h00;
    unique case (raddr)
      ucf_pkg::OFF_CTRL_A: begin
        rv = {s_q.rxc, s_q.txc, !s_q.buf_full, s_q.fe, 1'b0, s_q.pe,
              s_q.ctrl_a[ucf_pkg::A_DBL], 1'b0};
      end
      ucf_pkg::OFF_CTRL_B: begin
        rv = {3'h0, s_q.ctrl_b[4:2], s_q.rx_data[8], s_q.ctrl_b[ucf_pkg::B_TX_NINTH]};
      end
      ucf_pkg::OFF_CTRL_C:   rv = s_q.ctrl_c;
      ucf_pkg::OFF_DIV_LOW:  rv = s_q.div[7:0];
      ucf_pkg::OFF_DIV_HIGH: rv = {4'h0, s_q.div[11:8]};
      ucf_pkg::OFF_DATA:     rv = s_q.rx_data[7:0];
      ucf_pkg::OFF_PIN_DIR:  rv = {7'h00, s_q.xck_dir};
      default: rd_ok = 1'b0;
    endcase
    if (rready && s_q.rval) begin
      s_d.rval = 1'b0;
    end
    if (rd_go) begin
      s_d.rval  = 1'b1;
      s_d.rdata = {24'h000000, rd_ok ? rv : 8'h00};
      s_d.rresp = rd_ok ? ucf_pkg::RESP_OKAY : ucf_pkg::RESP_SLVERR;
    end
    s_d.arrdy = !s_d.rval;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.ctrl_a   <= ucf_pkg::RST_CTRL_A;
      s_q.ctrl_b   <= ucf_pkg::RST_CTRL_B;
      s_q.ctrl_c   <= ucf_pkg::RST_CTRL_C;
      s_q.div      <= ucf_pkg::RST_DIV;
      s_q.baud_cnt <= ucf_pkg::RST_DIV;
      s_q.txd      <= 1'b1;
      s_q.tx_st    <= ucf_pkg::TX_IDLE;
      s_q.rx_st    <= ucf_pkg::RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ucf_top
`default_nettype wire

/* verif/ucf_top_assertions.sv */
// Port-level checks for the serial port core
`timescale 1ns/1ps
`default_nettype none
module ucf_top_chk (
  input wire logic        aclk,    // Clock
  input wire logic        aresetn, // Reset, low
  input wire logic        awvalid, // AW valid
  input wire logic        awready, // AW ready
  input wire logic        wvalid,  // W valid
  input wire logic        wready,  // W ready
  input wire logic [1:0]  bresp,   // B code
  input wire logic        bvalid,  // B valid
  input wire logic        bready,  // B ready
  input wire logic        arvalid, // AR valid
  input wire logic        arready, // AR ready
  input wire logic [31:0] rdata,   // R data
  input wire logic [1:0]  rresp,   // R code
  input wire logic        rvalid,  // R valid
  input wire logic        rready,  // R ready
  input wire logic        txd_out, // Serial out
  input wire logic        xck_oe   // Clock pin drive
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_b_late;
    !bvalid ##1 bvalid;
  endsequence
  chk_reset_idle: assert property ($rose(aresetn) |-> txd_out && !xck_oe && !bvalid)
    else $error("outputs not idle after reset");
  chk_write_answer: assert property (s_wr_both |=> s_b_late)
    else $error("write response not two cycles after take");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  chk_ready_back: assert property (bvalid && bready |=> awready && wready && !bvalid)
    else $error("write channels not ready after response");
endmodule : ucf_top_chk
bind ucf_top ucf_top_chk u_ucf_top_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .txd_out,
  .xck_oe);
`default_nettype wire

/* verif/ucf_line_model.sv */
// Line-side model: remote serial transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module ucf_line_model (
  input  wire logic aclk,    // System clock
  input  wire logic line_in, // Device serial output
  output var  logic line_out, // Device serial input
  output var  logic xck_drv   // Transfer clock into the device
);
  initial line_out = 1'b1;
  initial xck_drv = 1'b0;
  // Mid-bit sampling; bit 0 is the start bit
  task automatic grab(input int cyc, input int nb, output logic [15:0] bits, output bit ok);
    int i;
    bits = 16'h0000;
    ok = 1'b0;
    for (i = 0; i < 4000 && !ok; i++) begin
      @(posedge aclk);
      ok = (line_in === 1'b0);
    end
    repeat (cyc / 2) @(posedge aclk);
    for (i = 0; i < nb; i++) begin
      bits[i] = line_in;
      repeat (cyc) @(posedge aclk);
    end
  endtask : grab
  task automatic send(input int cyc, input int nb, input logic [15:0] bits);
    int i;
    for (i = 0; i < nb; i++) begin
      line_out <= bits[i];
      repeat (cyc) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask : send
  // Slave clocking: change on the first half, sample before the second
  task automatic clocked(input logic pol, input int half, input int nb, input logic [15:0] tx,
      output logic [15:0] bits);
    int i;
    bits = 16'h0000;
    xck_drv <= pol;
    repeat (half) @(posedge aclk);
    for (i = 0; i < nb; i++) begin
      xck_drv  <= !pol;
      line_out <= tx[i];
      // Half period well above two system clocks keeps the device in range
      repeat (half) @(posedge aclk);
      bits[i] = line_in;
      xck_drv <= pol;
      repeat (half) @(posedge aclk);
    end
  endtask : clocked
endmodule : ucf_line_model
`default_nettype wire

/* verif/ucf_top_tb.sv */
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module ucf_top_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, rxd_in, txd_out, xck_in, xck_out, xck_oe, x;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] got, expv, rxv;
  logic [8:0]  d;
  bit          ok;
  int          err_total, samples_checked, k, nb, cyc, t, csz;
  int          fn[5] = '{5, 7, 8, 9, 8};
  int          fp[5] = '{0, 2, 3, 2, 0};
  int          fs[5] = '{0, 0, 1, 0, 0};
  int          fd[5] = '{0, 0, 0, 0, 1};
  int          fv[5] = '{1, 1, 3, 1, 1};
  localparam logic [1:0] OK = ucf_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ucf_pkg::RESP_SLVERR;
  ucf_top u_ucf_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rxd_in, .txd_out, .xck_in, .xck_out, .xck_oe);
  ucf_line_model u_ucf_line_model (.aclk, .line_in(txd_out), .line_out(rxd_in),
    .xck_drv(xck_in));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : chk
  // Ready is raised only after valid shows, so the hold checks see a stall
  task automatic axw(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    if (n == 100) begin
      err_total++;
      give_verdict();
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    if (n == 100) begin
      err_total++;
      give_verdict();
    end
  endtask : axr
  function automatic logic [15:0] frame_bits(input logic [8:0] v, input int n, input int pm,
      input int s2, output int cnt);
    logic p;
    int i;
    frame_bits = 16'h0000;
    p = (pm == 3);
    for (i = 0; i < n; i++) begin
      frame_bits[i + 1] = v[i];
      p = p ^ v[i];
    end
    cnt = n + 1;
    if (pm >= 2) begin
      frame_bits[cnt] = p;
      cnt++;
    end
    frame_bits[cnt] = 1'b1;
    frame_bits[cnt + 1] = (s2 != 0);
    cnt = cnt + 1 + s2;
  endfunction : frame_bits
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("txd idle", 1, txd_out);
    chk("xck drive", 0, xck_oe);
    axr(8'h08, OK, rd);
    chk("ctrl_c reset", 8'h06, rd);
    axr(8'h1C, ER, rd);
    chk("unmapped read", 0, rd);
    axw(8'h1C, 8'hFF, ER);
    axw(8'h10, 8'h1F, OK);
    axr(8'h10, OK, rd);
    chk("divisor high", 8'h0F, rd);
    $display("test registers done");
    for (k = 0; k < 5; k++) begin
      d = 9'h1A5 ^ 9'(k * 51);
      csz = (fn[k] == 9) ? 7 : fn[k] - 5;
      cyc = (fv[k] + 1) * (fd[k] ? 8 : 16);
      expv = frame_bits(d, fn[k], fp[k], fs[k], nb);
      axw(8'h10, 8'h00, OK);
      axw(8'h0C, 8'(fv[k]), OK);
      axw(8'h00, 8'(fd[k] * 2 + 64), OK);
      axw(8'h04, 8'(24 + (csz / 4) * 4 + d[8]), OK);
      axw(8'h08, 8'(fp[k] * 16 + fs[k] * 8 + (csz % 4) * 2), OK);
      axw(8'h14, d[7:0], OK);
      u_ucf_line_model.grab(cyc, nb, got, ok);
      chk("start seen", 1, ok);
      chk("tx frame", expv, got);
      repeat (cyc) @(posedge aclk);
      axr(8'h00, OK, rd);
      chk("tx complete", 8'h40, rd & 8'h40);
    end
    $display("test transmit formats done");
    axw(8'h00, 8'h00, OK);
    axw(8'h0C, 8'h01, OK);
    axw(8'h04, 8'h18, OK);
    axw(8'h08, 8'h0E, OK);
    for (k = 0; k < 2; k++) begin
      d = k ? 9'h0C3 : 9'h05A;
      u_ucf_line_model.send(32, 11, {5'h00, 1'b1, 1'(k == 0), d[7:0], 1'b0});
      repeat (48) @(posedge aclk);
      axr(8'h00, OK, rd);
      chk("rx status", k ? 8'h90 : 8'h80, rd & 8'h90);
      axr(8'h14, OK, rd);
      chk("rx data", {23'h0, d}, rd);
    end
    $display("test receive done");
    axw(8'h08, 8'h46, OK);
    axw(8'h18, 8'h01, OK);
    chk("xck drive master", 1, xck_oe);
    axw(8'h14, 8'h3C, OK);
    for (k = 0; k < 2; k++) begin
      x = xck_out;
      for (t = 0; t < 100 && xck_out === x; t++) @(posedge aclk);
    end
    chk("xck half period", 2, t);
    repeat (200) @(posedge aclk);
    axw(8'h18, 8'h00, OK);
    chk("xck drive slave", 0, xck_oe);
    for (k = 0; k < 2; k++) begin
      d = k ? 9'h0A7 : 9'h0C5;
      // Bit 10 is the idle line after the single stop bit
      expv = frame_bits(d, 8, 0, 1, nb);
      rxv  = frame_bits(d ^ 9'h0FF, 8, 0, 1, t);
      axw(8'h08, 8'(8'h46 + k), OK);
      axw(8'h14, d[7:0], OK);
      u_ucf_line_model.clocked(1'(k), 8, nb, rxv, got);
      chk("slave tx frame", expv, got);
      axr(8'h00, OK, rd);
      chk("slave rx status", 8'h80, rd & 8'h90);
      axr(8'h14, OK, rd);
      chk("slave rx data", {24'h0, d[7:0] ^ 8'hFF}, rd);
    end
    $display("test slave clock done");
    axw(8'h08, 8'h06, OK);
    axw(8'h18, 8'h01, OK);
    chk("xck drive async", 0, xck_oe);
    $display("test clock pin done");
    give_verdict();
  end
endmodule : ucf_top_tb
`default_nettype wire
